/* cpsr_pkg.sv */
// Constants for the CPU pointer, stack and status register bank
package cpsr_pkg;
   // Register indexes; byte address on APB is four times the index
   localparam logic [7:0] IDX_CFG_PROTECT = 8'h04;
   localparam logic [7:0] IDX_DIRECT_EXT = 8'h08;
   localparam logic [7:0] IDX_X_EXT = 8'h09;
   localparam logic [7:0] IDX_Y_EXT = 8'h0A;
   localparam logic [7:0] IDX_Z_EXT = 8'h0B;
   localparam logic [7:0] IDX_JUMP_EXT = 8'h0C;
   localparam logic [7:0] IDX_SP_LOW = 8'h0D;
   localparam logic [7:0] IDX_SP_HIGH = 8'h0E;
   localparam logic [7:0] IDX_STATUS = 8'h0F;

   // Device sizing: presence and implemented-bit masks
   localparam logic Z_EXT_PRESENT = 1'b1;
   localparam logic [7:0] Z_EXT_MASK = 8'h03;
   localparam logic JUMP_EXT_PRESENT = 1'b1;
   localparam logic [7:0] JUMP_EXT_MASK = 8'h01;
   localparam logic [15:0] SP_MASK = 16'h3FFF;
   localparam logic [15:0] SP_RESET = 16'h3FFF;

   // Reset values
   localparam logic [7:0] Z_EXT_RESET = 8'h00;
   localparam logic [7:0] JUMP_EXT_RESET = 8'h00;
   localparam logic [7:0] STATUS_RESET = 8'h00;

   // Status bit positions
   localparam int unsigned BIT_I = 7;
   localparam int unsigned BIT_T = 6;
   localparam int unsigned BIT_H = 5;
   localparam int unsigned BIT_S = 4;
   localparam int unsigned BIT_V = 3;
   localparam int unsigned BIT_N = 2;
   localparam int unsigned BIT_Z = 1;
   localparam int unsigned BIT_C = 0;

   // Instructions during which interrupts stay blocked after a stack low write
   localparam logic [2:0] SP_BLOCK_INSTR = 3'h4;
endpackage : cpsr_pkg

/* cpsr_regs.sv */
// Pointer extension, stack pointer and status register bank on APB
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Indirect data address is Z extension byte above the 16-bit Z pointer.
// - Same extension feeds extended program reads and program stores.
// - Extension byte is the top byte of a 24-bit address over Z.
// - Only needed Z extension bits exist; others read zero.
// - Z extension register absent on small devices.
// - Extended jump and call place jump extension byte above Z.
// - Ordinary indirect jump and call ignore the jump extension byte.
// - Jump extension absent on small devices; unimplemented bits read zero.
// - Jump extension keeps only bits needed for program memory.
// - Stack pointer is high byte over low byte, 16 bits.
// - Reset loads stack pointer with top of internal SRAM.
// - Stack low write blocks interrupts four instructions or until next I/O write.
// - Stack pointer keeps only bits for data memory; others read zero.
// - Global enable clear means no interrupts are taken.
// - Taking an interrupt never clears global enable.
// - Changing global enable through the register adds one wait state.
// - Bit 6 stores the bit for bit store and bit load.
// - Bit 5 holds half carry.
// - Bit 4 always equals negative XOR overflow.
// - Bit 3 records two's complement overflow.
// - Bits 2 and 1 flag negative and zero results.
// - Bit 0 records carry.
module cpsr_regs
   import cpsr_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_srst,
   // APB slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   // Core: pointer addressing
   input wire logic [15:0] i_z_ptr,
   input wire logic i_ext_jump,
   output logic [23:0] o_z_addr,
   output logic [23:0] o_jump_addr,
   // Core: stack pointer updates
   input wire logic i_sp_we,
   input wire logic [15:0] i_sp_d,
   output logic [15:0] o_sp,
   // Core: flag updates
   input wire logic [7:0] i_flag_we,
   input wire logic [7:0] i_flag_d,
   input wire logic i_interrupt_enable_op,
   input wire logic i_interrupt_disable_op,
   input wire logic i_bit_store_op,
   input wire logic i_bit_store_val,
   output logic o_t_flag,
   output logic [7:0] o_status,
   // Core: instruction progress and interrupt gate
   input wire logic i_instr_done,
   input wire logic i_io_write,
   output logic o_irq_allow
);
   logic [7:0] z_ext_q;
   logic [7:0] jump_ext_q;
   logic [15:0] sp_q;
   logic [7:0] flags_q;
   logic [2:0] sp_block_q;
   logic waited_q;
   logic [7:0] status_view;
   logic [7:0] idx;
   logic idx_ok;
   logic access;
   logic wr_go;
   logic ie_change;

   // Index decode from a word address; read data ignores unaligned and high bits, writes miss on them, and both reads and writes set pslverr
   function automatic logic [7:0] reg_read(input logic [7:0] i);
      if (i == IDX_Z_EXT) begin
         reg_read = z_ext_q;
      end else if (i == IDX_JUMP_EXT) begin
         reg_read = jump_ext_q;
      end else if (i == IDX_SP_LOW) begin
         reg_read = sp_q[7:0];
      end else if (i == IDX_SP_HIGH) begin
         reg_read = sp_q[15:8];
      end else if (i == IDX_STATUS) begin
         reg_read = status_view;
      end else begin
         reg_read = 8'h00;
      end
   endfunction : reg_read

   assign idx = i_paddr[9:2];
   // Listed but not built here: protection and other extensions read zero
   assign idx_ok = (i_paddr[11:10] == 2'h0) && (i_paddr[1:0] == 2'h0) &&
      ((idx == IDX_CFG_PROTECT) || ((idx >= IDX_DIRECT_EXT) && (idx <= IDX_STATUS)));
   assign access = i_psel && i_penable;

   // Sign is derived, never stored, so it cannot drift from N and V
   assign status_view = {flags_q[7:5], flags_q[BIT_N] ^ flags_q[BIT_V], flags_q[3:0]};

   // A status write that flips the global enable stalls one cycle
   assign ie_change = i_pwrite && idx_ok && (idx == IDX_STATUS) &&
      (i_pwdata[BIT_I] != flags_q[BIT_I]);
   assign o_pready = !(access && ie_change && !waited_q);
   assign wr_go = access && o_pready && i_pwrite && idx_ok;
   assign o_pslverr = access && !idx_ok;

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         waited_q <= 1'b0;
      end else begin
         waited_q <= access && !o_pready;
      end
   end

   // Read data registered at the edge that ends the setup phase; reads change no state
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         o_prdata <= 32'h0000_0000;
      end else if (i_psel && !i_penable && !i_pwrite) begin
         o_prdata <= {24'h00_0000, reg_read(idx)};
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst || !Z_EXT_PRESENT) begin
         z_ext_q <= Z_EXT_RESET;
      end else if (wr_go && idx == IDX_Z_EXT) begin
         z_ext_q <= i_pwdata[7:0] & Z_EXT_MASK;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst || !JUMP_EXT_PRESENT) begin
         jump_ext_q <= JUMP_EXT_RESET;
      end else if (wr_go && idx == IDX_JUMP_EXT) begin
         jump_ext_q <= i_pwdata[7:0] & JUMP_EXT_MASK;
      end
   end

   // Core push/pop wins over a software byte write in the same cycle
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         sp_q <= SP_RESET;
      end else if (i_sp_we) begin
         sp_q <= i_sp_d & SP_MASK;
      end else if (wr_go && idx == IDX_SP_LOW) begin
         sp_q[7:0] <= i_pwdata[7:0] & SP_MASK[7:0];
      end else if (wr_go && idx == IDX_SP_HIGH) begin
         sp_q[15:8] <= i_pwdata[7:0] & SP_MASK[15:8];
      end
   end

   // Guard window so a two-byte stack update is not split by an interrupt
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         sp_block_q <= 3'h0;
      end else if (wr_go && idx == IDX_SP_LOW) begin
         sp_block_q <= SP_BLOCK_INSTR;
      end else if (wr_go || i_io_write) begin
         sp_block_q <= 3'h0;
      end else if (i_instr_done && sp_block_q != 3'h0) begin
         sp_block_q <= sp_block_q - 3'h1;
      end
   end

   // Software writes first, core flag updates override per bit
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         flags_q <= STATUS_RESET;
      end else begin
         for (int b = 0; b < 8; b++) begin
            if (b == BIT_I) begin
               if (i_interrupt_enable_op) begin
                  flags_q[b] <= 1'b1;
               end else if (i_interrupt_disable_op) begin
                  flags_q[b] <= 1'b0;
               end else if (wr_go && idx == IDX_STATUS) begin
                  flags_q[b] <= i_pwdata[b];
               end
            end else if (b == BIT_T && i_bit_store_op) begin
               flags_q[b] <= i_bit_store_val;
            end else if (b != BIT_S && i_flag_we[b]) begin
               flags_q[b] <= i_flag_d[b];
            end else if (b != BIT_S && wr_go && idx == IDX_STATUS) begin
               flags_q[b] <= i_pwdata[b];
            end
         end
      end
   end

   assign o_z_addr = {z_ext_q, i_z_ptr};
   assign o_jump_addr = i_ext_jump ? {jump_ext_q, i_z_ptr} : {8'h00, i_z_ptr};
   assign o_sp = sp_q;
   assign o_t_flag = flags_q[BIT_T];
   assign o_status = status_view;
   assign o_irq_allow = flags_q[BIT_I] && (sp_block_q == 3'h0);
endmodule : cpsr_regs

`default_nettype wire

/* cpsr_regs_assertions.sv */
// Port-level checker for the pointer, stack and status register bank
`timescale 1ns/1ps
`default_nettype none
module cpsr_regs_assertions
   import cpsr_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic o_pready,
   input wire logic [15:0] i_z_ptr,
   input wire logic i_ext_jump,
   input wire logic [23:0] o_z_addr,
   input wire logic [23:0] o_jump_addr,
   input wire logic [15:0] o_sp,
   input wire logic [7:0] o_status,
   input wire logic o_irq_allow
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_srst);
   // First access cycle of a status write that flips the global enable
   sequence gate_flip;
      i_psel && i_penable && !$past(i_penable) && i_pwrite && i_paddr == {2'h0, IDX_STATUS, 2'h0}
         && i_pwdata[7] != o_status[7];
   endsequence
   chk_gate_wait: assert property (gate_flip |-> !o_pready ##1 o_pready) else $error("no wait state");
   chk_spl_guard: assert property (i_psel && i_penable && i_pwrite && o_pready && i_paddr == {2'h0, IDX_SP_LOW, 2'h0}
      |=> !o_irq_allow) else $error("stack write left interrupts open");
   chk_z_concat: assert property (o_z_addr == {o_z_addr[23:16] & Z_EXT_MASK, i_z_ptr}) else $error("z addr");
   chk_jump_plain: assert property (!i_ext_jump |-> o_jump_addr == {8'h00, i_z_ptr}) else $error("jump ext used");
   chk_jump_ext: assert property (o_jump_addr[23:16] == (o_jump_addr[23:16] & JUMP_EXT_MASK)) else $error("jump");
   chk_sp_bits: assert property ((o_sp & ~SP_MASK) == 16'h0000) else $error("stack bits");
   chk_sign_xor: assert property (o_status[4] == (o_status[2] ^ o_status[3])) else $error("sign flag");
   chk_gate_off: assert property (!o_status[7] |-> !o_irq_allow) else $error("interrupts with gate off");
   chk_sp_reset: assert property (disable iff (1'h0) $fell(i_srst) |-> o_sp == SP_RESET) else $error("sp reset");
endmodule : cpsr_regs_assertions
`default_nettype wire

/* cpsr_core_model.sv */
// Core stand-in that retires instructions while running
`timescale 1ns/1ps
`default_nettype none
module cpsr_core_model (
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_run,
   output logic o_instr_done
);
   // Two-cycle instructions, so a guard that counts clocks instead of pulses shows up
   always_ff @(posedge i_clk) begin
      o_instr_done <= !i_srst && i_run && !o_instr_done;
   end
endmodule : cpsr_core_model
`default_nettype wire

/* cpsr_regs_test.sv */
// Self-checking bench for the register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fails++; $display("MISMATCH %0t bad value", $time); end end
module cpsr_regs_test;
   import cpsr_pkg::*;
   logic i_clk = 1'h0, i_srst = 1'h1, i_psel = 1'h0, i_penable = 1'h0, i_pwrite = 1'h0, i_ext_jump = 1'h0;
   logic i_sp_we = 1'h0, i_interrupt_enable_op = 1'h0, i_interrupt_disable_op = 1'h0, i_bit_store_op = 1'h0;
   logic i_bit_store_val = 1'h0, i_io_write = 1'h0, i_instr_done, run = 1'h0, o_pready, o_pslverr, o_t_flag;
   logic o_irq_allow, err;
   logic [11:0] i_paddr = 12'h000;
   logic [31:0] i_pwdata = 32'h0, o_prdata, rd;
   logic [15:0] i_z_ptr = 16'hA5C3, i_sp_d = 16'h0000, o_sp;
   logic [7:0] i_flag_we = 8'h00, i_flag_d = 8'h00, o_status;
   logic [23:0] o_z_addr, o_jump_addr;
   int fails = 0, comparisons = 0, n;
   cpsr_regs dut_u (.*);
   cpsr_core_model core_u (.i_clk(i_clk), .i_srst(i_srst), .i_run(run), .o_instr_done(i_instr_done));
   initial begin
      forever #25 i_clk = ~i_clk;
   end
   task automatic end_sim;
      $display("fails=%0d comparisons=%0d", fails, comparisons);
      if (fails == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : end_sim
   // One APB transfer; waits for pready under a bound
   task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
      @(posedge i_clk);
      i_psel <= 1'h1;
      i_pwrite <= w;
      i_paddr <= {2'h0, idx, 2'h0};
      i_pwdata <= {24'h0, d};
      @(posedge i_clk);
      i_penable <= 1'h1;
      n = 0;
      // Pready is combinational, so it is judged mid-cycle where it has settled
      do begin
         @(negedge i_clk);
         n++;
      end while (o_pready !== 1'h1 && n < 20);
      rd = o_prdata;
      err = o_pslverr;
      @(posedge i_clk);
      i_psel <= 1'h0;
      i_penable <= 1'h0;
      if (n >= 20) begin
         fails++;
         end_sim();
      end
   endtask : apb
   initial begin
      repeat (8) @(posedge i_clk);
      i_srst <= 1'h0;
      apb(1'h0, IDX_SP_HIGH, 8'h00);
      `CHK(rd, {24'h0, SP_RESET[15:8]})
      apb(1'h1, IDX_Z_EXT, 8'hFF);
      apb(1'h0, IDX_Z_EXT, 8'h00);
      `CHK(rd, {24'h0, Z_EXT_MASK})
      `CHK(o_z_addr, {Z_EXT_MASK, i_z_ptr})
      apb(1'h1, IDX_JUMP_EXT, 8'hFF);
      apb(1'h0, IDX_JUMP_EXT, 8'h00);
      `CHK(rd, {24'h0, JUMP_EXT_MASK})
      i_ext_jump <= 1'h1;
      @(posedge i_clk);
      @(posedge i_clk);
      `CHK(o_jump_addr, {JUMP_EXT_MASK, i_z_ptr})
      apb(1'h1, IDX_SP_HIGH, 8'hFF);
      apb(1'h1, IDX_STATUS, 8'h80);
      apb(1'h1, IDX_SP_LOW, 8'h12);
      @(posedge i_clk);
      `CHK(o_sp, 16'hFF12 & SP_MASK)
      run <= 1'h1;
      n = 0;
      do begin
         @(negedge i_clk);
         n++;
      end while (o_irq_allow !== 1'h1 && n < 30);
      `CHK(n, 2 * SP_BLOCK_INSTR + 1)
      @(posedge i_clk);
      i_bit_store_op <= 1'h1;
      i_bit_store_val <= 1'h1;
      i_sp_we <= 1'h1;
      i_sp_d <= 16'hFFFF;
      @(posedge i_clk);
      i_bit_store_op <= 1'h0;
      i_sp_we <= 1'h0;
      @(negedge i_clk);
      `CHK(o_t_flag, 1'h1)
      `CHK(o_sp, SP_MASK)
      @(posedge i_clk);
      i_interrupt_disable_op <= 1'h1;
      i_flag_we <= 8'h0C;
      i_flag_d <= 8'h04;
      @(posedge i_clk);
      i_interrupt_disable_op <= 1'h0;
      i_flag_we <= 8'h00;
      apb(1'h0, IDX_STATUS, 8'h00);
      `CHK(rd, 32'h54)
      `CHK(o_irq_allow, 1'h0)
      apb(1'h0, 8'h00, 8'h00);
      `CHK(err, 1'h1)
      end_sim();
   end
endmodule : cpsr_regs_test
bind cpsr_regs cpsr_regs_assertions chk_u (.*);
`default_nettype wire
